/* bench/prcc_top_monitor.sv */
// Purpose: port-level checks of the power, reset and clock control block
// Assumes: single clock domain, synchronous active-low reset
// Notes:   halt and idle are told apart by o_timer0_run while o_core_run is low
`timescale 1ns/10ps

module prcc_top_monitor
    import prcc_pkg::*;
#(
    parameter logic [17:0] HALT_WAKE_CYC = 18'h0_0032
)(
    input wire logic       i_clk,          // system clock
    input wire logic       i_rstn,         // sync reset, active low
    input wire logic [7:0] i_addr,         // register address
    input wire logic [7:0] i_wdata,        // write data
    input wire logic       i_wr,           // write strobe
    input wire logic       i_rd,           // read strobe
    input wire logic [7:0] o_rdata,        // read data
    input wire logic       i_watchdog_tmo, // watchdog pulse
    input wire logic       i_ext_rst_n,    // reset pin
    input wire logic       i_wakeup,       // wake event
    input wire logic [2:0] o_thr_sel,      // threshold out
    input wire logic       o_monitor_en,   // monitor powered
    input wire logic       o_brownout_en,  // brown-out powered
    input wire logic       o_osc_run,      // oscillator on
    input wire logic       o_core_run,     // core runs
    input wire logic       o_timer0_run,   // timer 0 on
    input wire logic       o_sys_rst_n     // system reset
);
    logic [17:0] low_cnt_r;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // cycles the core has been stopped
    always_ff @(posedge i_clk)
        low_cnt_r <= o_core_run ? 18'h0_0000 : low_cnt_r + 18'h0_0001;

    a_thr_write: assert property ((i_wr && i_addr == 8'h00 && o_core_run)
        |=> o_thr_sel == $past(i_wdata[7:5])) else $error("threshold not applied");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    a_wo_read: assert property ($past(i_rd && (i_addr == 8'h01 || i_addr == 8'h02))
        |-> o_rdata == 8'h00) else $error("write-only register read nonzero");
    a_mon_run: assert property (o_monitor_en == o_core_run)
        else $error("monitor enable wrong");
    a_halt_off: assert property ((!o_core_run && !o_timer0_run && o_sys_rst_n)
        |-> !o_osc_run && !o_brownout_en) else $error("halt left circuits on");
    a_idle_off: assert property ((o_timer0_run && !o_core_run)
        |-> !o_brownout_en && !o_monitor_en) else $error("idle left circuits on");
    a_halt_entry: assert property ((i_wr && i_addr == 8'h01 && i_wdata[0] && o_core_run)
        |-> ##2 (!o_core_run && !o_timer0_run)) else $error("halt not entered");
    a_idle_entry: assert property ((i_wr && i_addr == 8'h01 && i_wdata[1:0] == 2'h2
        && o_core_run) |-> ##2 (!o_core_run && o_timer0_run)) else $error("idle not entered");
    a_idle_wake: assert property ((o_timer0_run && !o_core_run && i_wakeup)
        |-> ##[1:4] o_core_run) else $error("idle wake too slow");
    a_halt_delay: assert property (($rose(o_core_run) && !$past(o_timer0_run)
        && $past(o_sys_rst_n)) |-> low_cnt_r >= HALT_WAKE_CYC) else $error("halt delay short");
    a_wdog_rst: assert property ((i_watchdog_tmo && o_sys_rst_n) |=> !o_sys_rst_n)
        else $error("watchdog reset missed");
    a_pin_rst: assert property ($fell(i_ext_rst_n) |-> ##[1:4] !o_sys_rst_n)
        else $error("pin reset missed");
endmodule

/* bench/prcc_top_test.sv */
// Purpose: self-checking bench of the power, reset and clock control block
// Assumes: 100 MHz clock, shortened start-up counts
// Notes:   reset pin pulse is shortened to cycles, not milliseconds
`timescale 1ns/10ps

module prcc_top_test
    import prcc_pkg::*;
;
    localparam logic [17:0] HW = 18'h0_0032;
    localparam logic [17:0] RS = 18'h0_0028;
    logic       i_clk, i_rstn, i_wr, i_rd, i_supply_below, i_power_on_rst, i_brownout_rst;
    logic       i_watchdog_tmo, i_ext_rst_n, i_wakeup, i_clock_input, ck_on;
    logic [7:0] i_addr, i_wdata, o_rdata, d;
    logic [2:0] o_thr_sel;
    logic       o_monitor_en, o_brownout_en, o_osc_run, o_instr_en, o_core_run;
    logic       o_timer0_run, o_sys_rst_n;
    int         n_errors, n_compared, cyc, n, c, e;

    prcc_top #(.HALT_WAKE_CYC(HW), .RST_START_CYC(RS)) dut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_supply_below(i_supply_below), .i_power_on_rst(i_power_on_rst),
        .i_brownout_rst(i_brownout_rst), .i_watchdog_tmo(i_watchdog_tmo),
        .i_ext_rst_n(i_ext_rst_n), .i_wakeup(i_wakeup), .i_clock_input(i_clock_input),
        .o_thr_sel(o_thr_sel), .o_monitor_en(o_monitor_en), .o_brownout_en(o_brownout_en),
        .o_osc_run(o_osc_run), .o_instr_en(o_instr_en), .o_core_run(o_core_run),
        .o_timer0_run(o_timer0_run), .o_sys_rst_n(o_sys_rst_n));

    always #5 i_clk = ~i_clk;
    always @(posedge i_clk)
        if (ck_on)
            i_clock_input <= ~i_clock_input;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] ls_val(input logic [2:0] t, input logic f);
        return {t, 4'h0, f};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, v);
    endtask

    task automatic wait_run(input int lim, output int k);
        k = 0;
        do
        begin
            @(posedge i_clk);
            #1 k++;
        end while (o_core_run !== 1'b1 && k < lim);
    endtask

    task automatic cnt_ins(input int len, output int k);
        k = 0;
        repeat (len)
        begin
            @(posedge i_clk);
            #1 k += (o_instr_en === 1'b1);
        end
    endtask

    task automatic report_and_stop();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    initial
    begin
        {i_clk, i_addr, i_wdata, i_wr, i_rd, i_supply_below, i_power_on_rst} = '0;
        {i_brownout_rst, i_watchdog_tmo, i_wakeup, i_clock_input, ck_on, i_rstn} = '0;
        i_ext_rst_n = 1'b1;
        d = 8'($urandom(32'h32d1_2047));
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        wait_run(500, n);
        chk(n >= RS - 1 && n <= RS + 4, 1);
        rd(8'h00, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h01, 8'h00);
        rd(8'h7f, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h00, {i[2:0], 5'h1f});
            rd(8'h00, {i[2:0], 5'h00});
            chk(o_thr_sel, i[2:0]);
        end
        repeat (16)
        begin
            d = 8'($urandom);
            wr(8'h00, d);
            rd(8'h00, {d[7:5], 5'h00});
        end
        @(posedge i_clk);
        i_supply_below <= 1'b1;
        repeat (5) @(posedge i_clk);
        rd(8'h00, ls_val(d[7:5], 1'b1));
        chk(o_core_run, 1);
        @(posedge i_clk);
        i_supply_below <= 1'b0;
        repeat (5) @(posedge i_clk);
        rd(8'h00, ls_val(d[7:5], 1'b0));
        ck_on <= 1'b1;
        cnt_ins(1000, c);
        chk(c, 10);
        chk(o_osc_run, 1);
        for (int s = 1; s < 4; s++)
        begin
            wr(8'h03, 8'(s));
            rd(8'h03, 8'(s));
            chk(o_osc_run, 0);
            cnt_ins(1000, c);
            e = (s == 1) ? 500 : 125;
            chk(c >= e - 2 && c <= e + 2, 1);
        end
        wr(8'h03, 8'h01);
        wr(8'h01, 8'h02);
        repeat (3) @(posedge i_clk);
        #1 chk({o_core_run, o_timer0_run, o_monitor_en, o_brownout_en}, 4'h4);
        wait_run(20000, n);
        chk(n >= 16000 && n <= 16700, 1);
        wr(8'h02, 8'h00);
        wr(8'h03, 8'h00);
        wr(8'h01, 8'h02);
        wr(8'h00, 8'he0);
        repeat (3) @(posedge i_clk);
        #1 chk(o_osc_run, 1);
        @(posedge i_clk);
        i_wakeup <= 1'b1;
        wait_run(50, n);
        @(posedge i_clk);
        i_wakeup <= 1'b0;
        chk(n <= 5, 1);
        wr(8'h02, 8'h00);
        repeat (1000) @(posedge i_clk);
        rd(8'h00, ls_val(d[7:5], 1'b0));
        repeat (20) @(posedge i_clk);
        #1 chk(o_core_run, 1);
        wr(8'h01, 8'h03);
        repeat (100) @(posedge i_clk);
        #1 chk({o_core_run, o_timer0_run, o_osc_run, o_brownout_en, o_monitor_en}, 0);
        @(posedge i_clk);
        i_wakeup <= 1'b1;
        @(posedge i_clk);
        i_wakeup <= 1'b0;
        wait_run(500, n);
        chk(n >= HW - 1 && n <= HW + 7, 1);
        repeat (20) @(posedge i_clk);
        #1 chk(o_core_run, 1);
        wr(8'h02, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h00, 8'he0);
            @(posedge i_clk);
            case (k)
                0: i_watchdog_tmo <= 1'b1;
                1: i_power_on_rst <= 1'b1;
                2: i_brownout_rst <= 1'b1;
                default: i_ext_rst_n <= 1'b0;
            endcase
            repeat (k == 0 ? 1 : 4) @(posedge i_clk);
            {i_watchdog_tmo, i_power_on_rst, i_brownout_rst} <= 3'h0;
            i_ext_rst_n <= 1'b1;
            #1 chk(o_sys_rst_n, 0);
            wait_run(500, n);
            rd(8'h00, 8'h00);
        end
        report_and_stop();
    end
endmodule

bind prcc_top prcc_top_monitor #(.HALT_WAKE_CYC(HALT_WAKE_CYC)) mon (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_watchdog_tmo(i_watchdog_tmo), .i_ext_rst_n(i_ext_rst_n),
    .i_wakeup(i_wakeup), .o_thr_sel(o_thr_sel), .o_monitor_en(o_monitor_en),
    .o_brownout_en(o_brownout_en), .o_osc_run(o_osc_run), .o_core_run(o_core_run),
    .o_timer0_run(o_timer0_run), .o_sys_rst_n(o_sys_rst_n));

/* rtl/prcc_params.svh */
// Purpose: constants of the power, reset and clock control block
// Assumes: system clock of 100 MHz
// Notes:   register offsets are byte indices on the 8-bit register port
`ifndef PRCC_PARAMS_SVH
`define PRCC_PARAMS_SVH

`define PRCC_CLK_MHZ          100
`define PRCC_INT_OSC_MHZ      2
`define PRCC_INT_DIV          2
`define PRCC_INT_PERIOD       (`PRCC_CLK_MHZ * `PRCC_INT_DIV / `PRCC_INT_OSC_MHZ)
`define PRCC_EXT_DIV          4
`define PRCC_HALT_WAKE_US     1000
`define PRCC_HALT_WAKE_CYC    (`PRCC_HALT_WAKE_US * `PRCC_CLK_MHZ)
`define PRCC_RST_START_US     2000
`define PRCC_RST_START_CYC    (`PRCC_RST_START_US * `PRCC_CLK_MHZ)
`define PRCC_T0_PERIOD        8192

`define PRCC_ADDR_LOW_SUPPLY  8'h00
`define PRCC_ADDR_MODE_ENTRY  8'h01
`define PRCC_ADDR_MODE_CLEAR  8'h02
`define PRCC_ADDR_CLOCK_CTRL  8'h03

`define PRCC_LS_FLAG_BIT      0
`define PRCC_LS_THR_LSB       5
`define PRCC_LS_THR_MSB       7
`define PRCC_ME_HALT_BIT      0
`define PRCC_ME_IDLE_BIT      1
`define PRCC_CC_SRC_LSB       0
`define PRCC_CC_SRC_MSB       1

`define PRCC_THR_RST          3'h0
`define PRCC_SRC_RST          2'h0
`define PRCC_SRC_INTERNAL     2'h0
`define PRCC_SRC_SQUARE       2'h1

`endif

/* rtl/prcc_pkg.sv */
// Purpose: types of the power, reset and clock control block
// Assumes: prcc_params.svh constants
// Notes:   the whole block state is one packed struct
package prcc_pkg;

typedef enum logic [2:0] {
    PRCC_RSTSEQ,
    PRCC_RUN,
    PRCC_HALT,
    PRCC_HALT_WAKE,
    PRCC_IDLE
} prcc_state_t;

typedef struct packed {
    prcc_state_t state;
    logic [17:0] dly_cnt;
    logic [6:0]  int_cnt;
    logic [1:0]  ext_cnt;
    logic [12:0] t0_cnt;
    logic [2:0]  thr_sel;
    logic [1:0]  clk_src;
    logic        low_flag;
    logic        halt_req;
    logic        idle_req;
    logic [1:0]  sup_sync;
    logic [1:0]  wake_sync;
    logic [1:0]  erst_sync;
    logic [1:0]  por_sync;
    logic [1:0]  bor_sync;
    logic [2:0]  cki_sync;
    logic        instr_en;
    logic [7:0]  rdata;
} prcc_regs_t;

endpackage

/* rtl/prcc_top.sv */
// Purpose: power mode, reset sequence and clock source control
// Assumes: 100 MHz i_clk; analog comparators outside the block
// Notes:   instruction clock is a one-cycle enable pulse, o_instr_en
`timescale 1ns/10ps
`include "prcc_params.svh"

module prcc_top
    import prcc_pkg::*;
#(
    parameter logic [17:0] HALT_WAKE_CYC = 18'(`PRCC_HALT_WAKE_CYC),
    parameter logic [17:0] RST_START_CYC = 18'(`PRCC_RST_START_CYC)
)(
    input  wire logic       i_clk,            // system clock
    input  wire logic       i_rstn,           // sync reset, active low
    input  wire logic [7:0] i_addr,           // register address
    input  wire logic [7:0] i_wdata,          // register write data
    input  wire logic       i_wr,             // write strobe
    input  wire logic       i_rd,             // read strobe
    output logic      [7:0] o_rdata,          // read data, cycle after read
    input  wire logic       i_supply_below,   // comparator: supply below threshold
    input  wire logic       i_power_on_rst,   // power-on reset, high active
    input  wire logic       i_brownout_rst,   // brown-out comparator, high active
    input  wire logic       i_watchdog_tmo,   // watchdog timeout pulse
    input  wire logic       i_ext_rst_n,      // external reset pin, low active
    input  wire logic       i_wakeup,         // multi-input wake-up event
    input  wire logic       i_clock_input,    // external clock pin
    output logic      [2:0] o_thr_sel,        // threshold to comparator
    output logic            o_monitor_en,     // low-supply monitor powered
    output logic            o_brownout_en,    // brown-out circuit powered
    output logic            o_osc_run,        // internal oscillator running
    output logic            o_instr_en,       // instruction clock enable pulse
    output logic            o_core_run,       // core may execute
    output logic            o_timer0_run,     // timer 0 and watchdog clocked
    output logic            o_sys_rst_n       // system reset, low active
);

    // divider end points, one below each period
    localparam logic [6:0]  INT_LAST = 7'(`PRCC_INT_PERIOD - 1);
    localparam logic [1:0]  EXT_LAST = 2'(`PRCC_EXT_DIV - 1);
    localparam logic [12:0] T0_LAST  = 13'(`PRCC_T0_PERIOD - 1);

    localparam prcc_regs_t PRCC_RST = '{
        state:     PRCC_RSTSEQ,
        dly_cnt:   18'h0_0000,
        int_cnt:   7'h00,
        ext_cnt:   2'h0,
        t0_cnt:    13'h0000,
        thr_sel:   `PRCC_THR_RST,
        clk_src:   `PRCC_SRC_RST,
        low_flag:  1'b0,
        halt_req:  1'b0,
        idle_req:  1'b0,
        sup_sync:  2'h0,
        wake_sync: 2'h0,
        erst_sync: 2'h3,
        por_sync:  2'h0,
        bor_sync:  2'h0,
        cki_sync:  3'h0,
        instr_en:  1'b0,
        rdata:     8'h00
    };

    prcc_regs_t s_r;
    prcc_regs_t s_nxt;

    // per-cycle helpers, all set at the top of the comb block
    logic rst_src;
    logic osc_on;
    logic mon_on;
    logic cki_rise;
    logic tick;
    logic wr_en;

    always_comb
    begin
        s_nxt    = s_r;
        rst_src  = 1'b0;
        osc_on   = 1'b0;
        mon_on   = 1'b0;
        cki_rise = 1'b0;
        tick     = 1'b0;
        wr_en    = 1'b0;

        s_nxt.sup_sync  = {s_r.sup_sync[0], i_supply_below};
        s_nxt.wake_sync = {s_r.wake_sync[0], i_wakeup};
        s_nxt.erst_sync = {s_r.erst_sync[0], i_ext_rst_n};
        s_nxt.por_sync  = {s_r.por_sync[0], i_power_on_rst};
        s_nxt.bor_sync  = {s_r.bor_sync[0], i_brownout_rst};
        s_nxt.cki_sync  = {s_r.cki_sync[1:0], i_clock_input};
        s_nxt.rdata     = 8'h00;
        s_nxt.instr_en  = 1'b0;

        // monitor and brown-out off in halt and idle
        mon_on = (s_r.state == PRCC_RUN);

        // oscillator stops in halt or on external source
        osc_on = (s_r.clk_src == `PRCC_SRC_INTERNAL)
               && (s_r.state != PRCC_HALT) && (s_r.state != PRCC_HALT_WAKE);

        // internal 2 MHz halved, 1 MHz tick
        if (osc_on)
        begin
            if (s_r.int_cnt == INT_LAST)
            begin
                s_nxt.int_cnt = 7'h00;
                tick          = 1'b1;
            end
            else
            begin
                s_nxt.int_cnt = s_r.int_cnt + 7'h01;
            end
        end
        else
        begin
            s_nxt.int_cnt = 7'h00;
        end

        // external pin edge, only while not halted
        cki_rise = s_r.cki_sync[1] && !s_r.cki_sync[2]
                 && (s_r.state != PRCC_HALT) && (s_r.state != PRCC_HALT_WAKE);

        // source code picks the tick origin
        case (s_r.clk_src)
            `PRCC_SRC_INTERNAL:
            begin
                // internal tick already formed above
                s_nxt.ext_cnt = 2'h0;
            end
            `PRCC_SRC_SQUARE:
            begin
                if (cki_rise)
                begin
                    tick = 1'b1;
                end
            end
            default:
            begin
                // crystal or rc divided by four
                if (cki_rise)
                begin
                    s_nxt.ext_cnt = s_r.ext_cnt + 2'h1;
                    tick          = (s_r.ext_cnt == EXT_LAST);
                end
            end
        endcase

        s_nxt.instr_en = tick && (s_r.state == PRCC_RUN || s_r.state == PRCC_IDLE);

        // flag frozen while monitor is off
        if (mon_on)
        begin
            s_nxt.low_flag = s_r.sup_sync[1];
        end
        else
        begin
            // monitor off: last reading kept for software
            s_nxt.low_flag = s_r.low_flag;
        end

        wr_en = i_wr && (s_r.state == PRCC_RUN);

        // flag only reaches the read port
        if (i_rd)
        begin
            case (i_addr)
                `PRCC_ADDR_LOW_SUPPLY:
                begin
                    s_nxt.rdata[`PRCC_LS_THR_MSB:`PRCC_LS_THR_LSB] = s_r.thr_sel;
                    s_nxt.rdata[`PRCC_LS_FLAG_BIT]                 = s_r.low_flag;
                end
                `PRCC_ADDR_MODE_ENTRY,
                `PRCC_ADDR_MODE_CLEAR:
                begin
                    s_nxt.rdata = 8'h00;
                end
                `PRCC_ADDR_CLOCK_CTRL:
                begin
                    s_nxt.rdata[`PRCC_CC_SRC_MSB:`PRCC_CC_SRC_LSB] = s_r.clk_src;
                end
                default:
                begin
                    s_nxt.rdata = 8'h00;
                end
            endcase
        end

        if (wr_en)
        begin
            case (i_addr)
                `PRCC_ADDR_LOW_SUPPLY:
                begin
                    s_nxt.thr_sel = i_wdata[`PRCC_LS_THR_MSB:`PRCC_LS_THR_LSB];
                end
                `PRCC_ADDR_MODE_ENTRY:
                begin
                    s_nxt.halt_req = i_wdata[`PRCC_ME_HALT_BIT];
                    s_nxt.idle_req = i_wdata[`PRCC_ME_IDLE_BIT];
                end
                `PRCC_ADDR_MODE_CLEAR:
                begin
                    // mode clear is accepted with no effect here
                end
                `PRCC_ADDR_CLOCK_CTRL:
                begin
                    s_nxt.clk_src = i_wdata[`PRCC_CC_SRC_MSB:`PRCC_CC_SRC_LSB];
                    s_nxt.ext_cnt = 2'h0;
                end
                default:
                begin
                    s_nxt.rdata = s_nxt.rdata;
                end
            endcase
        end

        case (s_r.state)
            PRCC_RSTSEQ:
            begin
                if (s_r.dly_cnt >= RST_START_CYC - 18'h0_0001)
                begin
                    s_nxt.state   = PRCC_RUN;
                    s_nxt.dly_cnt = 18'h0_0000;
                end
                else
                begin
                    s_nxt.dly_cnt = s_r.dly_cnt + 18'h0_0001;
                end
            end
            PRCC_RUN:
            begin
                if (s_r.halt_req)
                begin
                    s_nxt.state = PRCC_HALT;
                end
                else if (s_r.idle_req)
                begin
                    s_nxt.state  = PRCC_IDLE;
                    s_nxt.t0_cnt = 13'h0000;
                end
            end
            PRCC_HALT:
            begin
                if (s_r.wake_sync[1])
                begin
                    s_nxt.state    = PRCC_HALT_WAKE;
                    s_nxt.dly_cnt  = 18'h0_0000;
                    s_nxt.halt_req = 1'b0;
                    s_nxt.idle_req = 1'b0;
                end
            end
            PRCC_HALT_WAKE:
            begin
                if (s_r.dly_cnt >= HALT_WAKE_CYC - 18'h0_0001)
                begin
                    s_nxt.state   = PRCC_RUN;
                    s_nxt.dly_cnt = 18'h0_0000;
                end
                else
                begin
                    s_nxt.dly_cnt = s_r.dly_cnt + 18'h0_0001;
                end
            end
            PRCC_IDLE:
            begin
                if (tick)
                begin
                    s_nxt.t0_cnt = s_r.t0_cnt + 13'h0001;
                end
                if (s_r.wake_sync[1] || (tick && s_r.t0_cnt == T0_LAST))
                begin
                    s_nxt.state    = PRCC_RUN;
                    s_nxt.idle_req = 1'b0;
                end
            end
            default:
            begin
                s_nxt.state = PRCC_RSTSEQ;
            end
        endcase

        // any reset source restarts the sequence
        // watchdog is on this clock, so no synchroniser
        // brown-out counts only in run, while the monitor is powered
        rst_src = s_r.por_sync[1] || !s_r.erst_sync[1] || i_watchdog_tmo
                || (s_r.bor_sync[1] && mon_on);
        if (rst_src)
        begin
            s_nxt           = PRCC_RST;
            s_nxt.sup_sync  = {s_r.sup_sync[0], i_supply_below};
            s_nxt.wake_sync = {s_r.wake_sync[0], i_wakeup};
            s_nxt.erst_sync = {s_r.erst_sync[0], i_ext_rst_n};
            s_nxt.por_sync  = {s_r.por_sync[0], i_power_on_rst};
            s_nxt.bor_sync  = {s_r.bor_sync[0], i_brownout_rst};
            s_nxt.cki_sync  = {s_r.cki_sync[1:0], i_clock_input};
        end
    end

    // one register for the whole state
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            s_r <= PRCC_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // code 0 highest threshold, code 7 lowest
    assign o_thr_sel     = s_r.thr_sel;
    assign o_rdata       = s_r.rdata;
    assign o_monitor_en  = (s_r.state == PRCC_RUN);
    // brown-out off in halt, and in idle
    assign o_brownout_en = (s_r.state == PRCC_RUN) || (s_r.state == PRCC_RSTSEQ);
    assign o_osc_run     = (s_r.clk_src == `PRCC_SRC_INTERNAL)
                         && (s_r.state != PRCC_HALT) && (s_r.state != PRCC_HALT_WAKE);
    // instruction clock as an enable pulse
    assign o_instr_en    = s_r.instr_en;
    assign o_core_run    = (s_r.state == PRCC_RUN);
    // timer 0 and watchdog clocked in idle
    assign o_timer0_run  = (s_r.state == PRCC_RUN) || (s_r.state == PRCC_IDLE);
    // system held in reset through start-up delay
    assign o_sys_rst_n   = (s_r.state != PRCC_RSTSEQ);

endmodule
